//--- rtl/pps_pkg.sv
package pps_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_SYNC_CTRL = 6'h10;
    localparam logic [5:0] IDX_FRONT_END = 6'h11;
    localparam logic [5:0] IDX_RATE_AVE = 6'h12;
    localparam logic [5:0] IDX_SLOT_CFG = 6'h20;

    localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
    localparam logic [7:0] FRONT_END_RESET = 8'h03;
    localparam logic [7:0] RATE_AVE_RESET = 8'h88;
    localparam logic [7:0] SLOT_CFG_RESET = 8'h01;

    localparam int SOFT_RESYNC_BIT = 4;

    // Sync-pin function codes.
    localparam logic [3:0] FN_MUX = 4'h0;
    localparam logic [3:0] FN_SAMPLE_TRIG = 4'h2;
    localparam logic [3:0] FN_EXPO_TRIG = 4'h6;
    localparam logic [3:0] FN_PIN_RESYNC = 4'h9;
    localparam logic [3:0] FN_SINGLE_SAMPLE = 4'hA;

    localparam logic [4:0] SR_DUAL_FIRST = 5'h06;
    localparam logic [4:0] SR_DUAL_LAST = 5'h09;
    localparam logic [19:0] OFFSET_SINGLE = 20'h02000;
    localparam logic [19:0] OFFSET_DUAL = 20'h01000;
    localparam logic [15:0] FULL_SCALE_BASE_NA = 16'h1000;
    // LSB weight in units of 0.5 fA: 7.8125 pA is 15625 units.
    localparam logic [16:0] LSB_BASE_HALF_FA = 17'h03D09;

    // Clocking: 10 MHz system clock, 32768 Hz sampling clock.
    localparam int SYS_CLK_HZ = 10000000;
    localparam int SAMPLE_CLK_HZ = 32768;
    localparam int CLK_PERIOD_NS = 100;

    // Exposure timing in ns.
    localparam int TINT0_NS = 14800;
    localparam int TINT1_NS = 29400;
    localparam int TINT2_NS = 58700;
    localparam int TINT3_NS = 117300;
    localparam int SETTLE_NS = 6000;
    localparam int PULSE_EXTRA_NS = 500;
    localparam int POWERUP_NS = 100000;
    localparam int TINT0_CYC = (TINT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TINT1_CYC = (TINT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TINT2_CYC = (TINT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TINT3_CYC = (TINT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXTRA_CYC = (PULSE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MAX_SLOTS = 3'h6;

    typedef struct packed {
        logic timestampPushEnable;
        logic dacTagEnable;
        logic spare;
        logic softwareResync;
        logic [3:0] syncFunction;
    } pps_sync_ctrl_t;

    typedef struct packed {
        logic ambientCancelOff;
        logic addDarkOffset;
        logic [1:0] spare;
        logic [1:0] adcRangeSelect;
        logic [1:0] integrationTimeCode;
    } pps_front_end_t;

    typedef struct packed {
        logic [4:0] sampleRateCode;
        logic [2:0] sampleAveraging;
    } pps_rate_ave_t;

    typedef struct packed {
        logic [3:0] spare;
        logic muxStatesUsed;
        logic [2:0] slotCount;
    } pps_slot_cfg_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT,
        ST_POWERUP,
        ST_ARM,
        ST_EXPOSE,
        ST_PUSH
    } pps_state_t;
endpackage : pps_pkg

//--- rtl/pps_sample_sync.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Writing one to software resync aborts the sample, restarts at once, self-clears.
// - Function 0000 drives the pin as mux control when mux states are used.
// - Function 0010 takes pin falls as sample triggers; exposures timed internally.
// - Function 0110 takes sample and exposure timing from the pin.
// - Function 1001 pin fall terminates the running sample and starts a new one.
// - Function 1010 pin fall powers up, runs one sample, pushes, then shuts down.
// - Dark offset adds 8192 counts in single-pulse rates, 4096 in dual-pulse rates.
// - ADC range doubles LSB from 7.8125 pA and full scale from 4096 nA.
// - Integration codes give 14.8 to 117.3 us; pulse adds settling plus 0.5 us.
// - Five-bit rate field in upper bits, reset 0x11, timed by 32768 Hz clock.
// - Unsupportable rates are replaced by the highest supportable one, also on readback.
// - Rate codes select single-pulse or dual-pulse rates as tabulated.
module pps_sample_sync
    import pps_pkg::*;
(
    input wire logic clk_sys, // System clock, 10 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic [5:0] address, // Avalon word address.
    input wire logic read, // Avalon read.
    input wire logic write, // Avalon write.
    input wire logic [3:0] byteenable, // Avalon byte enables.
    input wire logic [31:0] writedata, // Avalon write data.
    output logic [31:0] readdata, // Avalon read data.
    output logic waitrequest, // Avalon wait request.
    input wire logic syncPinIn, // Sync pin level seen at the pad.
    output logic syncPinOut, // Sync pin drive level.
    output logic syncPinOe, // Sync pin output enable.
    input wire logic sensorValid, // Raw conversion strobe.
    input wire logic [18:0] sensorData, // Raw conversion result.
    output logic sensorOutValid, // Offset-corrected data strobe.
    output logic [19:0] sensorOut, // Offset-corrected data.
    output logic sampleStart, // Pulse at the start of each sample.
    output logic exposureActive, // High during an exposure.
    output logic [2:0] slotIndex, // Current sequence slot.
    output logic fifoPush, // Pulse when an averaged sample is pushed.
    output logic poweredOn, // Analog front end powered.
    output logic ambientCancelOff, // Ambient cancellation disabled.
    output logic timestampPushEnable, // Timestamp push enabled.
    output logic [15:0] fullScaleNa, // Full scale in nA.
    output logic [16:0] lsbWeight, // LSB weight in 0.5 fA units.
    output logic [10:0] integrationCycles, // Integration time in clocks.
    output logic [10:0] pulseCycles // LED pulse width in clocks.
);
    pps_sync_ctrl_t syncCtrl_reg;
    pps_front_end_t frontEnd_reg;
    pps_rate_ave_t rateAve_reg;
    pps_slot_cfg_t slotCfg_reg;
    pps_state_t state_reg;
    logic ack_reg;
    logic wrTake;
    logic [7:0] wrByte;
    logic syncMeta_reg, syncSync_reg, syncPrev_reg;
    logic pinFall, pinRise;
    logic [23:0] phase_reg;
    logic tick_reg;
    logic [12:0] tickCnt_reg;
    logic [15:0] expCnt_reg;
    logic [6:0] aveCnt_reg;
    logic [2:0] slots;
    logic [4:0] effRate, maxRate;
    logic dualPulse;
    logic resync, startInternal;

    function automatic logic [12:0] rateSps(input logic [4:0] code);
        case (code)
            5'h00, 5'h06: rateSps = 13'h0019;
            5'h01, 5'h07: rateSps = 13'h0032;
            5'h02, 5'h08: rateSps = 13'h0054;
            5'h03, 5'h09: rateSps = 13'h0064;
            5'h04: rateSps = 13'h00C8;
            5'h05: rateSps = 13'h0190;
            5'h0A: rateSps = 13'h0008;
            5'h0B: rateSps = 13'h0010;
            5'h0C: rateSps = 13'h0020;
            5'h0D: rateSps = 13'h0040;
            5'h0E: rateSps = 13'h0080;
            5'h0F: rateSps = 13'h0100;
            5'h10: rateSps = 13'h0200;
            5'h11: rateSps = 13'h0400;
            5'h12: rateSps = 13'h0800;
            5'h13: rateSps = 13'h1000;
            default: rateSps = 13'h1FFF;
        endcase
    endfunction : rateSps

    // Sampling-clock ticks per sample, rounded to the nearest tick.
    function automatic logic [12:0] periodTicks(input logic [4:0] code);
        case (code)
            5'h00, 5'h06: periodTicks = 13'h051F;
            5'h01, 5'h07: periodTicks = 13'h028F;
            5'h02, 5'h08: periodTicks = 13'h0186;
            5'h03, 5'h09: periodTicks = 13'h0148;
            5'h04: periodTicks = 13'h00A4;
            5'h05: periodTicks = 13'h0052;
            5'h0A: periodTicks = 13'h1000;
            5'h0B: periodTicks = 13'h0800;
            5'h0C: periodTicks = 13'h0400;
            5'h0D: periodTicks = 13'h0200;
            5'h0E: periodTicks = 13'h0100;
            5'h0F: periodTicks = 13'h0080;
            5'h10: periodTicks = 13'h0040;
            5'h11: periodTicks = 13'h0020;
            5'h12: periodTicks = 13'h0010;
            default: periodTicks = 13'h0008;
        endcase
    endfunction : periodTicks

    // Highest supportable rate code for pulse mode, exposures and integration time.
    function automatic logic [4:0] maxCode(input logic dual, input logic [2:0] n, input logic [1:0] t);
        logic [19:0] row;
        row = 20'h0;
        case ({dual, n})
            4'h1: row = {5'h11, 5'h12, 5'h12, 5'h13};
            4'h2: row = {5'h10, 5'h11, 5'h11, 5'h12};
            4'h3: row = {5'h10, 5'h10, 5'h11, 5'h11};
            4'h4: row = {5'h05, 5'h10, 5'h10, 5'h11};
            4'h5: row = {5'h0F, 5'h10, 5'h10, 5'h10};
            4'h6: row = {5'h0F, 5'h05, 5'h10, 5'h10};
            4'h9: row = {5'h09, 5'h09, 5'h09, 5'h09};
            4'hA: row = {5'h08, 5'h08, 5'h08, 5'h09};
            4'hB: row = {5'h07, 5'h07, 5'h07, 5'h07};
            default: row = {5'h06, 5'h06, 5'h06, 5'h06};
        endcase
        maxCode = row[5 * t +: 5];
    endfunction : maxCode

    assign slots = (slotCfg_reg.slotCount == 3'h0) ? 3'h1 :
        (slotCfg_reg.slotCount > MAX_SLOTS) ? MAX_SLOTS : slotCfg_reg.slotCount;
    assign dualPulse = (rateAve_reg.sampleRateCode >= SR_DUAL_FIRST) &&
        (rateAve_reg.sampleRateCode <= SR_DUAL_LAST);
    assign maxRate = maxCode(dualPulse, slots, frontEnd_reg.integrationTimeCode);
    assign effRate = (rateSps(rateAve_reg.sampleRateCode) > rateSps(maxRate)) ?
        maxRate : rateAve_reg.sampleRateCode;

    always_comb begin
        case (frontEnd_reg.integrationTimeCode)
            2'h0: integrationCycles = 11'(TINT0_CYC);
            2'h1: integrationCycles = 11'(TINT1_CYC);
            2'h2: integrationCycles = 11'(TINT2_CYC);
            default: integrationCycles = 11'(TINT3_CYC);
        endcase
    end
    assign pulseCycles = integrationCycles + 11'(SETTLE_CYC) + 11'(EXTRA_CYC);
    assign fullScaleNa = FULL_SCALE_BASE_NA << frontEnd_reg.adcRangeSelect;
    assign lsbWeight = LSB_BASE_HALF_FA << frontEnd_reg.adcRangeSelect;
    assign ambientCancelOff = frontEnd_reg.ambientCancelOff;
    assign timestampPushEnable = syncCtrl_reg.timestampPushEnable;

    // Avalon slave: one wait state, then the access completes.
    assign waitrequest = (read | write) & ~ack_reg;
    assign wrTake = write & ack_reg & byteenable[0];
    assign wrByte = writedata[7:0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~ack_reg) begin
            case (address)
                IDX_SYNC_CTRL: readdata <= {24'h0, syncCtrl_reg};
                IDX_FRONT_END: readdata <= {24'h0, frontEnd_reg};
                IDX_RATE_AVE: readdata <= {24'h0, effRate, rateAve_reg.sampleAveraging};
                IDX_SLOT_CFG: readdata <= {24'h0, slotCfg_reg};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            syncCtrl_reg <= SYNC_CTRL_RESET;
            frontEnd_reg <= FRONT_END_RESET;
            rateAve_reg <= RATE_AVE_RESET;
            slotCfg_reg <= SLOT_CFG_RESET;
        end else begin
            // The resync bit lives one cycle, so only a read started right after the write can see it set.
            syncCtrl_reg.softwareResync <= 1'b0;
            if (wrTake) begin
                case (address)
                    IDX_SYNC_CTRL: syncCtrl_reg <= wrByte;
                    IDX_FRONT_END: frontEnd_reg <= wrByte;
                    IDX_RATE_AVE: rateAve_reg <= wrByte;
                    IDX_SLOT_CFG: slotCfg_reg <= wrByte;
                    default: ;
                endcase
            end
        end
    end

    // Pin synchroniser and edge detection.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            syncMeta_reg <= 1'b1;
            syncSync_reg <= 1'b1;
            syncPrev_reg <= 1'b1;
        end else begin
            syncMeta_reg <= syncPinIn;
            syncSync_reg <= syncMeta_reg;
            syncPrev_reg <= syncSync_reg;
        end
    end
    assign pinFall = syncPrev_reg & ~syncSync_reg;
    assign pinRise = ~syncPrev_reg & syncSync_reg;

    // 32768 Hz sampling clock derived by phase accumulation.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 24'h0;
            tick_reg <= 1'b0;
        end else if (phase_reg + 24'(SAMPLE_CLK_HZ) >= 24'(SYS_CLK_HZ)) begin
            phase_reg <= phase_reg + 24'(SAMPLE_CLK_HZ) - 24'(SYS_CLK_HZ);
            tick_reg <= 1'b1;
        end else begin
            phase_reg <= phase_reg + 24'(SAMPLE_CLK_HZ);
            tick_reg <= 1'b0;
        end
    end

    assign resync = syncCtrl_reg.softwareResync ||
        (syncCtrl_reg.syncFunction == FN_PIN_RESYNC && pinFall);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tickCnt_reg <= 13'h0;
        end else if (sampleStart) begin
            tickCnt_reg <= 13'h0;
        end else if (tick_reg) begin
            tickCnt_reg <= tickCnt_reg + 13'h1;
        end
    end

    always_comb begin
        case (syncCtrl_reg.syncFunction)
            FN_SAMPLE_TRIG: startInternal = pinFall;
            FN_EXPO_TRIG: startInternal = pinFall;
            FN_SINGLE_SAMPLE: startInternal = 1'b0;
            default: startInternal = tick_reg && (tickCnt_reg >= periodTicks(effRate) - 13'h1);
        endcase
    end

    // Sample sequencer.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_WAIT;
            expCnt_reg <= 16'h0;
            slotIndex <= 3'h0;
            sampleStart <= 1'b0;
            fifoPush <= 1'b0;
        end else begin
            sampleStart <= 1'b0;
            fifoPush <= 1'b0;
            if (resync) begin
                state_reg <= ST_EXPOSE;
                slotIndex <= 3'h0;
                expCnt_reg <= 16'h0;
                sampleStart <= 1'b1;
            end else begin
                case (state_reg)
                    ST_OFF: begin
                        if (syncCtrl_reg.syncFunction != FN_SINGLE_SAMPLE) begin
                            state_reg <= ST_WAIT;
                        end else if (pinFall) begin
                            state_reg <= ST_POWERUP;
                            expCnt_reg <= 16'h0;
                        end
                    end
                    ST_WAIT: begin
                        if (syncCtrl_reg.syncFunction == FN_SINGLE_SAMPLE) begin
                            state_reg <= ST_OFF;
                        end else if (startInternal) begin
                            state_reg <= ST_EXPOSE;
                            slotIndex <= 3'h0;
                            expCnt_reg <= 16'h0;
                            sampleStart <= 1'b1;
                        end
                    end
                    ST_POWERUP: begin
                        if (expCnt_reg >= 16'(POWERUP_CYC - 1)) begin
                            state_reg <= ST_EXPOSE;
                            slotIndex <= 3'h0;
                            expCnt_reg <= 16'h0;
                            sampleStart <= 1'b1;
                        end else begin
                            expCnt_reg <= expCnt_reg + 16'h1;
                        end
                    end
                    ST_ARM: begin
                        if (syncCtrl_reg.syncFunction != FN_EXPO_TRIG || pinFall) begin
                            state_reg <= ST_EXPOSE;
                            expCnt_reg <= 16'h0;
                        end
                    end
                    ST_EXPOSE: begin
                        expCnt_reg <= expCnt_reg + 16'h1;
                        if (syncCtrl_reg.syncFunction == FN_EXPO_TRIG ? pinRise :
                            expCnt_reg >= 16'(pulseCycles) - 16'h1) begin
                            if (slotIndex + 3'h1 >= slots) begin
                                state_reg <= ST_PUSH;
                            end else begin
                                slotIndex <= slotIndex + 3'h1;
                                state_reg <= ST_ARM;
                            end
                        end
                    end
                    ST_PUSH: begin
                        fifoPush <= (aveCnt_reg == 7'((8'h1 << rateAve_reg.sampleAveraging) - 8'h1));
                        slotIndex <= 3'h0;
                        state_reg <= (syncCtrl_reg.syncFunction == FN_SINGLE_SAMPLE) ? ST_OFF : ST_WAIT;
                    end
                    default: state_reg <= ST_WAIT;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aveCnt_reg <= 7'h0;
        end else if (resync) begin
            aveCnt_reg <= 7'h0;
        end else if (state_reg == ST_PUSH) begin
            aveCnt_reg <= fifoPushNext() ? 7'h0 : aveCnt_reg + 7'h1;
        end
    end

    function automatic logic fifoPushNext();
        fifoPushNext = (aveCnt_reg >= 7'((8'h1 << rateAve_reg.sampleAveraging) - 8'h1));
    endfunction : fifoPushNext

    assign exposureActive = (state_reg == ST_EXPOSE);
    assign poweredOn = (state_reg != ST_OFF);
    assign syncPinOe = (syncCtrl_reg.syncFunction == FN_MUX) && slotCfg_reg.muxStatesUsed;
    assign syncPinOut = syncPinOe && exposureActive;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sensorOut <= 20'h0;
            sensorOutValid <= 1'b0;
        end else begin
            sensorOutValid <= sensorValid;
            if (sensorValid) begin
                sensorOut <= {1'b0, sensorData} +
                    (frontEnd_reg.addDarkOffset ? (dualPulse ? OFFSET_DUAL : OFFSET_SINGLE) : 20'h0);
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence swResyncWrite;
        wrTake && address == IDX_SYNC_CTRL && wrByte[SOFT_RESYNC_BIT];
    endsequence
    sequence freshSample;
        sampleStart && state_reg == ST_EXPOSE && slotIndex == 3'h0;
    endsequence

    soft_resync_a: assert property (swResyncWrite |=> ##1 (freshSample and !syncCtrl_reg.softwareResync))
        else $error("software resync did not restart the sample");
    mux_drive_a: assert property (syncPinOe |-> syncCtrl_reg.syncFunction == FN_MUX)
        else $error("sync pin driven outside mux mode");
    pin_resync_a: assert property (syncCtrl_reg.syncFunction == FN_PIN_RESYNC && pinFall |=> freshSample)
        else $error("pin fall did not restart the sample");
    single_off_a: assert property (state_reg == ST_PUSH && syncCtrl_reg.syncFunction == FN_SINGLE_SAMPLE
        |=> state_reg == ST_OFF && !poweredOn)
        else $error("single sample mode did not shut down");
    dark_offset_a: assert property (sensorValid && frontEnd_reg.addDarkOffset && !dualPulse
        && $stable(frontEnd_reg) |=> sensorOut == {1'b0, $past(sensorData)} + 20'h02000)
        else $error("dark offset wrong");
    range_scale_a: assert property (fullScaleNa == (16'h1000 << frontEnd_reg.adcRangeSelect)
        && lsbWeight >= 17'h03D09)
        else $error("range scaling wrong");
    pulse_width_a: assert property (frontEnd_reg.integrationTimeCode == 2'h0 |-> pulseCycles == 11'h0D5)
        else $error("pulse width wrong");
    rate_clamp_a: assert property (rateSps(effRate) <= rateSps(maxRate))
        else $error("unsupportable rate in use");
    resync_clean_a: assert property (resync |=> aveCnt_reg == 7'h0 && slotIndex == 3'h0)
        else $error("resync kept old state");
    trig_input_a: assert property (syncCtrl_reg.syncFunction == FN_SAMPLE_TRIG && state_reg == ST_WAIT
        && pinFall && !resync |=> sampleStart)
        else $error("sample trigger ignored");
endmodule : pps_sample_sync

//--- verif/pps_sync_partner.sv
`timescale 1ns/1ps
module pps_sync_partner (
    input wire logic clk_sys, // System clock.
    input wire logic nrst, // Reset, active low.
    input wire logic fire, // Request one low pulse.
    output logic pin // Sync pin level, pulled up when idle.
);
    int cnt;
    // The trigger source pulls the line low for eight clocks, then lets the pull-up win.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
        // It stands for the master of a pair and fires only once the bench has set this slave up.
        end else if (fire) begin
            cnt <= 8;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign pin = (cnt == 0);
endmodule : pps_sync_partner

//--- verif/pps_sample_sync_tb.sv
`timescale 1ns/1ps
module pps_sample_sync_tb;
    import pps_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, sensorValid = 1'b0, fire = 1'b0, wqS;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, q, rdS;
    logic fifoPush, ambientCancelOff, timestampPushEnable;
    logic [18:0] sensorData = 19'h0;
    logic [19:0] lf = 20'h14791, sensorOut;
    logic [15:0] fullScaleNa;
    logic [16:0] lsbWeight;
    logic [10:0] integrationCycles, pulseCycles;
    logic [2:0] slotIndex;
    logic waitrequest, syncPinIn, syncPinOut, syncPinOe, sensorOutValid, sampleStart, exposureActive, poweredOn;
    int mismatches = 0, total_checks = 0, cyc = 0, n, pushes = 0;
    int expQ[$];
    int tc[4] = '{148, 294, 587, 1173};
    pps_sample_sync pps_sample_sync_i (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .syncPinIn(syncPinIn), .syncPinOut(syncPinOut), .syncPinOe(syncPinOe), .sensorValid(sensorValid),
        .sensorData(sensorData), .sensorOutValid(sensorOutValid), .sensorOut(sensorOut), .sampleStart(sampleStart),
        .exposureActive(exposureActive), .slotIndex(slotIndex), .fifoPush(fifoPush), .poweredOn(poweredOn),
        .ambientCancelOff(ambientCancelOff), .timestampPushEnable(timestampPushEnable), .fullScaleNa(fullScaleNa),
        .lsbWeight(lsbWeight), .integrationCycles(integrationCycles), .pulseCycles(pulseCycles));
    pps_sync_partner pps_sync_partner_i (.clk_sys(clk_sys), .nrst(nrst), .fire(fire), .pin(syncPinIn));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [19:0] lfsr(input logic [19:0] v);
        return {v[18:0], v[19] ^ v[16]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // Waitrequest and read data are taken at each falling edge, half a clock before the rising edge, so they are the values of that edge.
    always @(negedge clk_sys) begin
        wqS = waitrequest;
        rdS = readdata;
        if (fifoPush === 1'b1) pushes++;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    always @(negedge clk_sys) begin
        if (sensorOutValid === 1'b1) chk("sensorOut", expQ.pop_front(), {12'h0, sensorOut});
    end
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        address <= a;
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        do @(posedge clk_sys); while (wqS !== 1'b0);
        r = rdS;
        write <= 1'b0;
        read <= 1'b0;
        @(negedge clk_sys);
    endtask : bus
    task automatic sense(input int off);
        lf = lfsr(lf);
        expQ.push_back(int'(lf[18:0]) + off);
        @(posedge clk_sys);
        sensorValid <= 1'b1;
        sensorData <= lf[18:0];
        @(posedge clk_sys);
        sensorValid <= 1'b0;
    endtask : sense
    task automatic pulse();
        @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask : pulse
    task automatic seen(input string nm);
        n = 0;
        while (sampleStart !== 1'b1 && n < 1200) begin
            @(negedge clk_sys);
            n++;
        end
        chk(nm, 32'h1, {31'h0, sampleStart});
        chk(nm, 32'h0, {29'h0, slotIndex});
        chk(nm, 32'h1, {31'h0, exposureActive});
    endtask : seen
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b1, 6'h3F, 8'h5A, q);
        bus(1'b0, IDX_SYNC_CTRL, 8'h00, q);
        chk("ctrl", 32'h00, q);
        bus(1'b0, IDX_RATE_AVE, 8'h00, q);
        chk("rate", 32'h88, q);
        bus(1'b0, 6'h3F, 8'h00, q);
        chk("unmapped", 32'h0, q);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, IDX_FRONT_END, 8'(c), q);
            chk("fs", 32'h1000 << c[3:2], {16'h0, fullScaleNa});
            chk("lsb", 32'h3D09 << c[3:2], {15'h0, lsbWeight});
            chk("tint", tc[c % 4], {21'h0, integrationCycles});
            chk("pw", tc[c % 4] + 65, {21'h0, pulseCycles});
        end
        bus(1'b1, IDX_RATE_AVE, 8'hA5, q);
        bus(1'b0, IDX_RATE_AVE, 8'h00, q);
        chk("clamp", 32'h8D, q);
        bus(1'b1, IDX_RATE_AVE, 8'h52, q);
        bus(1'b0, IDX_RATE_AVE, 8'h00, q);
        chk("keep", 32'h52, q);
        bus(1'b1, IDX_FRONT_END, 8'hC3, q);
        chk("alc", 32'h1, {31'h0, ambientCancelOff});
        repeat (2) sense(8192);
        bus(1'b1, IDX_RATE_AVE, 8'h40, q);
        sense(4096);
        bus(1'b1, IDX_FRONT_END, 8'h03, q);
        sense(0);
        bus(1'b1, IDX_SLOT_CFG, 8'h09, q);
        chk("oe", 32'h1, {31'h0, syncPinOe});
        bus(1'b1, IDX_SYNC_CTRL, 8'h10, q);
        seen("swsync");
        chk("pinout", 32'h1, {31'h0, syncPinOut});
        bus(1'b0, IDX_SYNC_CTRL, 8'h00, q);
        chk("selfclear", 32'h0, q);
        for (int f = 0; f < 3; f++) begin
            logic [3:0] fn;
            fn = (f == 0) ? FN_SAMPLE_TRIG : (f == 1) ? FN_EXPO_TRIG : FN_PIN_RESYNC;
            // Pin triggers other than resync are only taken between samples, so let the running exposure finish first.
            for (int w = 0; w < 3000 && exposureActive !== 1'b0; w++) @(negedge clk_sys);
            chk("idle", 32'h0, {31'h0, exposureActive});
            bus(1'b1, IDX_SYNC_CTRL, {4'h8, fn}, q);
            chk("ts", 32'h1, {31'h0, timestampPushEnable});
            chk("oe", 32'h0, {31'h0, syncPinOe});
            pulse();
            seen("pin");
        end
        bus(1'b1, IDX_SYNC_CTRL, {4'h0, FN_SINGLE_SAMPLE}, q);
        pulse();
        for (int w = 0; w < 3000 && poweredOn !== 1'b0; w++) @(negedge clk_sys);
        chk("off", 32'h0, {31'h0, poweredOn});
        pulse();
        seen("oneshot");
        chk("pushes", 32'h4, pushes);
        wrap_up();
    end
endmodule : pps_sample_sync_tb
